// *** rtl/port_io_pkg.sv ***
`default_nettype none
package port_io_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_BIDIR_DATA = 8'h00;
  localparam logic [7:0] ADDR_BIDIR_DIR  = 8'h04;
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h08;
  localparam logic [7:0] ADDR_MIXED_DATA = 8'h0c;
  localparam logic [7:0] ADDR_TCTL_ZERO  = 8'h10;
  localparam logic [7:0] ADDR_TCTL_ONE   = 8'h14;
  localparam logic [7:0] ADDR_TCTL_TWO   = 8'h18;
  localparam logic [7:0] ADDR_RECOVERY   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h24;
  // port configuration bits
  localparam int CFG_OPEN_DRAIN = 0;
  localparam int CFG_DIGITAL    = 1;
  localparam int CFG_PULLUP     = 2;
  localparam int CFG_STOP       = 3;
  // timer control one fields
  localparam int TC1_MODE       = 7;
  localparam int TC1_SEL        = 6;
  localparam int TC1_FN_HI      = 5;
  localparam int TC1_FN_LO      = 4;
  // recovery register source field
  localparam int REC_SRC_HI     = 4;
  localparam int REC_SRC_LO     = 2;
  // status bits
  localparam int ST_EXT_A       = 0;
  localparam int ST_EXT_B       = 1;
  localparam int ST_EXT_C       = 2;
  localparam int ST_WAKE        = 3;
  // reset values
  localparam logic [7:0] DIR_RST  = 8'hff;
  localparam logic [7:0] TC1_RST  = 8'h00;
  localparam logic [2:0] SRC_RST  = 3'h0;
  // recovery source codes
  localparam logic [2:0] SRC_POR_ONLY     = 3'h0;
  localparam logic [2:0] SRC_NAND_B3_0    = 3'h1;
  localparam logic [2:0] SRC_NAND_B7_0    = 3'h2;
  localparam logic [2:0] SRC_NOR_M3_1     = 3'h3;
  localparam logic [2:0] SRC_NAND_M3_1    = 3'h4;
  localparam logic [2:0] SRC_NOR_M_AUX    = 3'h5;
  localparam logic [2:0] SRC_NAND_M_AUX   = 3'h6;
  localparam logic [2:0] SRC_NAND_M_B2_0  = 3'h7;
  // line 6 logic functions
  localparam logic [1:0] FN_AND  = 2'h0;
  localparam logic [1:0] FN_OR   = 2'h1;
  localparam logic [1:0] FN_NOR  = 2'h2;
  localparam logic [1:0] FN_NAND = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** rtl/wake_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface wake_if;
  logic [7:0] bidir;
  logic [7:0] dir;
  logic [3:1] mixed;
  logic [1:0] aux;
  logic [2:0] src;
  logic       digital;
  logic       hit;
  modport core_side (output bidir, output dir, output mixed, output aux,
                     output src, output digital, input hit);
  modport wake_side (input bidir, input dir, input mixed, input aux,
                     input src, input digital, output hit);
endinterface
`default_nettype wire

// *** rtl/stop_wake.sv ***
`timescale 1ns/100ps
`default_nettype none
module stop_wake
  import port_io_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  wake_if.wake_side wk
);
  typedef struct packed {
    logic hit;
  } wake_state_t;

  wake_state_t q;
  wake_state_t d;
  logic [7:0]  b_hi;
  logic [2:0]  m_hi;
  logic [2:0]  m_lo;

  // lines driven as outputs drop out of the gates; analog-mode inputs too
  always_comb begin
    b_hi = wk.bidir | ~wk.dir;
    m_hi = wk.digital ? wk.mixed : 3'h7;
    m_lo = wk.digital ? wk.mixed : 3'h0;
    d = q;
    case (wk.src)
      SRC_POR_ONLY:    d.hit = 1'b0;
      SRC_NAND_B3_0:   d.hit = ~&b_hi[3:0];
      SRC_NAND_B7_0:   d.hit = ~&b_hi;
      SRC_NOR_M3_1:    d.hit = ~|m_lo;
      SRC_NAND_M3_1:   d.hit = ~&m_hi;
      SRC_NOR_M_AUX:   d.hit = ~|{m_lo, wk.aux};
      SRC_NAND_M_AUX:  d.hit = ~&{m_hi, wk.aux};
      SRC_NAND_M_B2_0: d.hit = ~&{m_hi, b_hi[2:0]};
      default:         d.hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wk.hit = q.hit;

  a_por_only_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (wk.src == SRC_POR_ONLY) |=> !q.hit)
    else $error("recovery source por-only raised a wake hit");
  a_code7_nand: assert property (@(posedge aclk) disable iff (!aresetn)
    (wk.src == SRC_NAND_M_B2_0 && wk.digital && wk.dir[2:0] == 3'h7
     && wk.mixed == 3'h7 && wk.bidir[2:0] == 3'h7) |=> !q.hit)
    else $error("code 7 woke with all its lines high");
endmodule
`default_nettype wire

// *** rtl/port_io_top.sv ***
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - each bidirectional line is input or output, set per line by software
// - one push-pull or open-drain choice applies to every output line
// - after reset all bidirectional lines are inputs
// - one-time strap enables pull-ups on all eight lines together
// - bidirectional port is always usable for plain input and output
// - eight-input or and and of the lines serve as wake-up sources
// - line 0 feeds the edge detector in edge-measure mode with select bit set, mixed line 1 with it clear; low outside that mode
// - mixed lines 0-3 are inputs, 4-7 outputs; line 1 also counter input
// - mixed line 2 drives interrupt a, line 3 b, line 1 c
// - line 4 carries byte timer, 5 word timer, 6 combined logic output
// - timer control bits choose port data or timer outputs on lines 4-6
// - comparators are powered down while in stop mode
// - 3-bit recovery source selects por only or nand/nor groups of lines
//
module port_io_top
  import port_io_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [7:0]        bidir_in,
  output logic [7:0]             bidir_out,
  output logic [7:0]             bidir_oe,
  output logic                   bidir_pullup_en,
  input  wire logic              otp_pullup,
  input  wire logic [3:0]        mixed_in,
  output logic [7:4]             mixed_out,
  input  wire logic [1:0]        aux_wake_in,
  input  wire logic              byte_timer_out,
  input  wire logic              word_timer_out,
  output logic                   timer_count_in,
  output logic                   edge_measure_in,
  output logic                   ext_interrupt_a,
  output logic                   ext_interrupt_b,
  output logic                   ext_interrupt_c,
  output logic                   wake_or,
  output logic                   wake_and,
  output logic                   comparator_pd,
  output logic                   stop_mode,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]  bi_s1;
    logic [7:0]  bi_s2;
    logic [3:0]  mx_s1;
    logic [3:0]  mx_s2;
    logic [3:0]  mx_p;
    logic [1:0]  ax_s1;
    logic [1:0]  ax_s2;
    logic [7:0]  bi_lat;
    logic [7:0]  bi_dir;
    logic        od;
    logic        digital;
    logic        pu_en;
    logic        pu_caught;
    logic [7:4]  mx_lat;
    logic        tc0;
    logic [7:0]  tc1;
    logic        tc2;
    logic [2:0]  src;
    logic [3:0]  sts;
    logic [3:0]  msk;
    logic        stop;
    logic [7:0]  bi_out;
    logic [7:0]  bi_oe;
    logic [7:4]  mx_out;
    logic        irq;
    logic [2:0]  ext;
    logic        or_all;
    logic        and_all;
    logic        edge_tap;
    logic        cnt_in;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic        wen;
    logic        awrdy;
    logic        wrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } port_state_t;

  port_state_t q;
  port_state_t d;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic [7:0]  ra;
  logic [7:0]  rv;
  logic        comb6;

  wake_if wk ();

  stop_wake u_wake (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wk      (wk)
  );

  assign wk.bidir   = q.bi_s2;
  assign wk.dir     = q.bi_dir;
  assign wk.mixed   = q.mx_s2[3:1];
  assign wk.aux     = q.ax_s2;
  assign wk.src     = q.src;
  assign wk.digital = q.digital;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d     = q;
    ev    = 4'h0;
    clr   = 4'h0;
    ra    = {araddr[7:2], 2'b00};
    rv    = 8'h00;
    comb6 = 1'b0;

    // two-flop synchronisers for every pin input
    d.bi_s1 = bidir_in;
    d.bi_s2 = q.bi_s1;
    d.mx_s1 = mixed_in;
    d.mx_s2 = q.mx_s1;
    d.mx_p  = q.mx_s2;
    d.ax_s1 = aux_wake_in;
    d.ax_s2 = q.ax_s1;

    // strap caught once after reset release
    if (!q.pu_caught) begin
      d.pu_caught = 1'b1;
      d.pu_en     = otp_pullup;
    end

    // falling edge of an interrupt line is an event
    ev[ST_EXT_A] = q.mx_p[2] & ~q.mx_s2[2];
    ev[ST_EXT_B] = q.mx_p[3] & ~q.mx_s2[3];
    ev[ST_EXT_C] = q.mx_p[1] & ~q.mx_s2[1];
    d.ext        = {ev[ST_EXT_C], ev[ST_EXT_B], ev[ST_EXT_A]};

    // stop mode ends on a recovery hit
    if (q.stop && wk.hit) begin
      d.stop      = 1'b0;
      ev[ST_WAKE] = 1'b1;
    end

    // write channel: address and data taken in either order
    if (awvalid && q.awrdy) begin
      d.aw_have = 1'b1;
      d.wa      = {awaddr[7:2], 2'b00};
    end
    if (wvalid && q.wrdy) begin
      d.w_have = 1'b1;
      d.wd     = wdata[7:0];
      d.wen    = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      case (q.wa)
        ADDR_BIDIR_DATA: if (q.wen) d.bi_lat = q.wd;
        ADDR_BIDIR_DIR:  if (q.wen) d.bi_dir = q.wd;
        ADDR_PORT_CFG: begin
          if (q.wen) begin
            d.od      = q.wd[CFG_OPEN_DRAIN];
            d.digital = q.wd[CFG_DIGITAL];
            if (q.wd[CFG_STOP]) begin
              d.stop = 1'b1;
            end
          end
        end
        ADDR_MIXED_DATA: if (q.wen) d.mx_lat = q.wd[7:4];
        ADDR_TCTL_ZERO:  if (q.wen) d.tc0 = q.wd[0];
        ADDR_TCTL_ONE:   if (q.wen) d.tc1 = q.wd;
        ADDR_TCTL_TWO:   if (q.wen) d.tc2 = q.wd[0];
        ADDR_RECOVERY:   if (q.wen) d.src = q.wd[REC_SRC_HI:REC_SRC_LO];
        ADDR_IRQ_STATUS: if (q.wen) clr = q.wd[3:0];
        ADDR_IRQ_MASK:   if (q.wen) d.msk = q.wd[3:0];
        default:         d.bresp = RESP_SLVERR;
      endcase
    end
    d.awrdy = !d.aw_have && !d.bvalid;
    d.wrdy  = !d.w_have && !d.bvalid;

    // read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (ra)
        ADDR_BIDIR_DATA: rv = (q.bi_dir & q.bi_s2) | (~q.bi_dir & q.bi_lat);
        ADDR_BIDIR_DIR:  rv = q.bi_dir;
        ADDR_PORT_CFG:   rv = {4'h0, q.stop, q.pu_en, q.digital, q.od};
        ADDR_MIXED_DATA: rv = {q.mx_lat, q.mx_s2};
        ADDR_TCTL_ZERO:  rv = {7'h00, q.tc0};
        ADDR_TCTL_ONE:   rv = q.tc1;
        ADDR_TCTL_TWO:   rv = {7'h00, q.tc2};
        ADDR_RECOVERY:   rv = {3'h0, q.src, 2'h0};
        ADDR_IRQ_STATUS: rv = {4'h0, q.sts};
        ADDR_IRQ_MASK:   rv = {4'h0, q.msk};
        default:         d.rresp = RESP_SLVERR;
      endcase
      d.rdata = {24'h000000, rv};
    end
    d.arrdy = !d.rvalid;

    // a new event wins over a clear in the same cycle
    d.sts = (q.sts & ~clr) | ev;
    d.irq = |(d.sts & d.msk);

    // bidirectional pin drive; an input line is never driven
    d.bi_out = d.bi_lat & ~{8{d.od}};
    d.bi_oe  = ~d.bi_dir & ({8{~d.od}} | ~d.bi_lat);

    // wake gates across the whole port
    d.or_all  = |q.bi_s2;
    d.and_all = &q.bi_s2;

    // edge tap and counter input
    d.cnt_in   = q.mx_s2[1];
    d.edge_tap = q.tc1[TC1_MODE] &
                 (q.tc1[TC1_SEL] ? q.bi_s2[0] : q.mx_s2[1]);

    // mixed output lines: port data or timer outputs
    case (q.tc1[TC1_FN_HI:TC1_FN_LO])
      FN_AND:  comb6 = byte_timer_out & word_timer_out;
      FN_OR:   comb6 = byte_timer_out | word_timer_out;
      FN_NOR:  comb6 = ~(byte_timer_out | word_timer_out);
      FN_NAND: comb6 = ~(byte_timer_out & word_timer_out);
      default: comb6 = 1'b0;
    endcase
    d.mx_out[4] = q.tc0 ? byte_timer_out : q.mx_lat[4];
    d.mx_out[5] = q.tc2 ? word_timer_out : q.mx_lat[5];
    d.mx_out[6] = (!q.tc1[TC1_MODE] && q.tc1[TC1_SEL]) ? comb6 : q.mx_lat[6];
    d.mx_out[7] = q.mx_lat[7];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.bi_dir <= DIR_RST;
      q.tc1    <= TC1_RST;
      q.src    <= SRC_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign awready         = q.awrdy;
  assign wready          = q.wrdy;
  assign bvalid          = q.bvalid;
  assign bresp           = q.bresp;
  assign arready         = q.arrdy;
  assign rvalid          = q.rvalid;
  assign rresp           = q.rresp;
  assign rdata           = q.rdata;
  assign bidir_out       = q.bi_out;
  assign bidir_oe        = q.bi_oe;
  assign bidir_pullup_en = q.pu_en;
  assign mixed_out       = q.mx_out;
  assign timer_count_in  = q.cnt_in;
  assign edge_measure_in = q.edge_tap;
  assign ext_interrupt_a = q.ext[0];
  assign ext_interrupt_b = q.ext[1];
  assign ext_interrupt_c = q.ext[2];
  assign wake_or         = q.or_all;
  assign wake_and        = q.and_all;
  assign comparator_pd   = q.stop;
  assign stop_mode       = q.stop;
  assign irq             = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  a_dir_after_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (q.bi_dir == DIR_RST) ##1 (q.bi_oe == 8'h00))
    else $error("port lines not inputs after reset");
  a_input_undriven: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |-> ((q.bi_oe & q.bi_dir) == 8'h00))
    else $error("input line driven");
  a_output_driven: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.od |-> (q.bi_oe == ~q.bi_dir))
    else $error("push-pull output line not driven");
  a_open_drain_low: assert property (@(posedge aclk) disable iff (!aresetn)
    q.od |-> ((q.bi_out & q.bi_oe) == 8'h00))
    else $error("open-drain line drove high");
  a_readback_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && q.arrdy && ra == ADDR_BIDIR_DATA && q.bi_dir == 8'hff)
    |=> (q.rdata[7:0] == $past(q.bi_s2)))
    else $error("input read did not return pin level");
  a_pullup_strap: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.pu_caught) |-> (q.pu_en == $past(otp_pullup)))
    else $error("pull-up strap not caught");
  a_wake_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (q.or_all == |$past(q.bi_s2)) && (q.and_all == &$past(q.bi_s2)))
    else $error("wake gates wrong");
  a_edge_tap_line0: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.tc1[TC1_MODE] && q.tc1[TC1_SEL]) |=> (q.edge_tap == $past(q.bi_s2[0])))
    else $error("edge tap not from line 0");
  a_irq_a_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(q.mx_s2[2])) |=> ext_interrupt_a ##1 !ext_interrupt_a)
    else $error("line 2 fall did not pulse interrupt a");
  a_irq_b_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(q.mx_s2[3])) |=> ext_interrupt_b ##1 !ext_interrupt_b)
    else $error("line 3 fall did not pulse interrupt b");
  a_irq_c_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(q.mx_s2[1])) |=> ext_interrupt_c ##1 !ext_interrupt_c)
    else $error("line 1 fall did not pulse interrupt c");
  a_line4_timer: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.tc0 && $stable(q.tc0)) |=> (mixed_out[4] == $past(byte_timer_out)))
    else $error("line 4 not carrying byte timer");
  a_stop_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.stop && wk.hit) |=> !comparator_pd && q.sts[ST_WAKE])
    else $error("recovery hit did not leave stop");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (awvalid && awready && wvalid && wready) |-> ##2 bvalid)
    else $error("write answer late");

  c_write: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);
  c_wake: cover property (@(posedge aclk) disable iff (!aresetn) q.stop && wk.hit);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule
`default_nettype wire

// *** verif/pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] bidir_out,
  input  wire logic [7:0] bidir_oe,
  input  wire logic       pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] bidir_in
);
  // an undriven line with no pull-up wanders: it shows the inverse of its last level
  logic [7:0] float_q = 8'h00;

  always_ff @(posedge aclk) begin
    float_q <= ~bidir_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the board yields to the port wherever the port drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (bidir_oe[i])
        bidir_in[i] = bidir_out[i];
      else if (ext_en[i])
        bidir_in[i] = ext_val[i];
      else if (pullup_en)
        bidir_in[i] = 1'b1;
      else
        bidir_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
  import port_io_pkg::*;
();
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [3:0]  mixed_in = 4'hf;
  logic [1:0]  aux_wake_in = 2'h3;
  logic        otp_pullup = 1'b1, byte_timer_out = 1'b0, word_timer_out = 1'b0;
  logic [7:0]  ext_val = 8'h00;
  logic [7:0]  ext_en = 8'hff;
  logic        awready, wready, bvalid, arready, rvalid, bidir_pullup_en;
  logic        timer_count_in, edge_measure_in, ext_interrupt_a, ext_interrupt_b;
  logic        ext_interrupt_c, wake_or, wake_and, comparator_pd, stop_mode, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  bidir_in, bidir_out, bidir_oe;
  logic [7:4]  mixed_out;
  int          num_errors = 0;
  int          tests_run = 0;
  logic [7:0]  wake_tab [4] = '{8'hff, 8'h00, 8'h01, 8'hfe};
  int          irq_line [3] = '{2, 3, 1};
  // wake pattern per recovery code 1..6: {bidir pins, mixed inputs, aux wake lines}
  logic [13:0] rec_tab [6] = '{{8'hfe, 4'hf, 2'h3}, {8'h7f, 4'hf, 2'h3}, {8'hff, 4'h1, 2'h3},
                               {8'hff, 4'hb, 2'h3}, {8'hff, 4'h1, 2'h0}, {8'hff, 4'hf, 2'h2}};

  port_io_top port_io_top_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .bidir_in, .bidir_out, .bidir_oe, .bidir_pullup_en, .otp_pullup, .mixed_in,
    .mixed_out, .aux_wake_in, .byte_timer_out, .word_timer_out, .timer_count_in,
    .edge_measure_in, .ext_interrupt_a, .ext_interrupt_b, .ext_interrupt_c, .wake_or,
    .wake_and, .comparator_pd, .stop_mode, .irq
  );

  pin_model pin_model_i (
    .aclk, .bidir_out, .bidir_oe, .pullup_en(bidir_pullup_en), .ext_val, .ext_en, .bidir_in
  );

  initial begin
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({6'h0, bresp}, {6'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata[7:0], exp);
    chk({6'h0, rresp}, {6'h0, er});
  endtask

  // pins pass two sync flops and an output register
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    #40000;
    num_errors++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(bidir_oe, 8'h00);
    rd(ADDR_BIDIR_DIR, DIR_RST);
    rd(ADDR_PORT_CFG, 8'h04);
    chk({7'h0, bidir_pullup_en}, 8'h01);
    test_end("reset");

    ext_val <= 8'h3c;
    wr(ADDR_BIDIR_DATA, 8'ha5);
    wr(ADDR_BIDIR_DIR, 8'h0f);
    settle;
    chk(bidir_oe, 8'hf0);
    chk(bidir_out & bidir_oe, 8'ha0);
    rd(ADDR_BIDIR_DATA, 8'hac);
    wr(ADDR_PORT_CFG, 8'h01);
    settle;
    chk(bidir_oe, 8'h50);
    chk(bidir_out, 8'h00);
    wr(ADDR_PORT_CFG, 8'h00);
    wr(ADDR_BIDIR_DIR, 8'hff);
    ext_en <= 8'h00;
    settle;
    chk(bidir_oe, 8'h00);
    rd(ADDR_BIDIR_DATA, 8'hff);
    ext_en <= 8'hff;
    test_end("direction");

    foreach (wake_tab[i]) begin
      ext_val <= wake_tab[i];
      settle;
      chk({6'h0, wake_or, wake_and}, {6'h0, |wake_tab[i], &wake_tab[i]});
    end
    test_end("wake gates");

    wr(ADDR_TCTL_ONE, 8'hc0);
    for (int v = 0; v < 2; v++) begin
      ext_val <= {7'h7f, v[0]};
      mixed_in[1] <= ~v[0];
      settle;
      chk({6'h0, edge_measure_in, timer_count_in}, {6'h0, v[0], ~v[0]});
    end
    wr(ADDR_TCTL_ONE, 8'h80);
    settle;
    chk({7'h0, edge_measure_in}, 8'h00);
    test_end("edge tap");

    byte_timer_out <= 1'b1;
    word_timer_out <= 1'b0;
    wr(ADDR_MIXED_DATA, 8'h80);
    wr(ADDR_TCTL_ZERO, 8'h01);
    wr(ADDR_TCTL_TWO, 8'h01);
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_TCTL_ONE, {2'b01, f[1:0], 4'h0});
      settle;
      chk({4'h0, mixed_out}, {4'h0, 1'b1, f[0], 2'b01});
    end
    wr(ADDR_TCTL_ZERO, 8'h00);
    wr(ADDR_TCTL_TWO, 8'h00);
    wr(ADDR_TCTL_ONE, 8'h00);
    wr(ADDR_MIXED_DATA, 8'ha0);
    settle;
    chk({4'h0, mixed_out}, 8'h0a);
    rd(ADDR_MIXED_DATA, {4'ha, mixed_in});
    test_end("mixed outputs");

    mixed_in <= 4'hf;
    settle;
    wr(ADDR_IRQ_STATUS, 8'h0f);
    wr(ADDR_IRQ_MASK, 8'h07);
    foreach (irq_line[i]) begin
      mixed_in[irq_line[i]] <= 1'b0;
      settle;
      chk({7'h0, irq}, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'(1 << i));
      mixed_in[irq_line[i]] <= 1'b1;
      wr(ADDR_IRQ_STATUS, 8'(1 << i));
      settle;
      chk({7'h0, irq}, 8'h00);
    end
    wr(ADDR_IRQ_MASK, 8'h00);
    mixed_in[2] <= 1'b0;
    settle;
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h01);
    mixed_in[2] <= 1'b1;
    wr(ADDR_IRQ_STATUS, 8'h0f);
    test_end("interrupts");

    wr(ADDR_RECOVERY, {3'h0, SRC_POR_ONLY, 2'h0});
    ext_val <= 8'h00;
    wr(ADDR_PORT_CFG, 8'h0a);
    settle;
    chk({6'h0, comparator_pd, stop_mode}, 8'h03);
    ext_val <= 8'hff;
    settle;
    wr(ADDR_RECOVERY, {3'h0, SRC_NAND_M_B2_0, 2'h0});
    settle;
    chk({6'h0, comparator_pd, stop_mode}, 8'h03);
    ext_val <= 8'hfb;
    settle;
    chk({6'h0, comparator_pd, stop_mode}, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h08);
    test_end("stop");

    for (int c = 1; c < 7; c++) begin
      ext_val <= 8'hff;
      mixed_in <= 4'hf;
      aux_wake_in <= 2'h3;
      settle;
      wr(ADDR_RECOVERY, {3'h0, c[2:0], 2'h0});
      wr(ADDR_PORT_CFG, 8'h0a);
      settle;
      chk({6'h0, comparator_pd, stop_mode}, 8'h03);
      {ext_val, mixed_in, aux_wake_in} <= rec_tab[c-1];
      settle;
      chk({6'h0, comparator_pd, stop_mode}, 8'h00);
    end
    ext_val <= 8'hff;
    mixed_in <= 4'hf;
    aux_wake_in <= 2'h3;
    test_end("recovery codes");

    wr(ADDR_BIDIR_DIR, 8'h00);
    settle;
    chk(bidir_oe, 8'hff);
    aresetn <= 1'b0;
    otp_pullup <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(bidir_oe, 8'h00);
    chk({7'h0, bidir_pullup_en}, 8'h00);
    rd(ADDR_PORT_CFG, 8'h00);
    rd(ADDR_BIDIR_DIR, DIR_RST);
    test_end("second reset");

    wr(8'h30, 8'h55, RESP_SLVERR);
    rd(8'h30, 8'h00, RESP_SLVERR);
    test_end("unmapped");
    final_report;
  end
endmodule
`default_nettype wire
